// file: hdl/rrit_decode.sv
`timescale 1ns/1ps
`include "rrit_cfg.svh"

// Behaviour
// - a2 splits ports from timer
// - ports only with io select, a2 low
// - a1:a0 pick port data or direction
// - timer write a1:a0 sets prescale
// - a3 on timer write routes irq pin
// - timer reads: count, flag; a3 low on a count read disables
// - rom read only; others read and write
// - region select separates rom from rest
// - up to seven devices share rom
// - two pins masked as chip selects
// - single device ram ignores a8
// - second select may be port pin
// - per device rom, ram, io codes
// - zero before flag, then count down
// - timer write or count read clears flag, set wins
// - flag with routing pulls pin low
// - direction one drives, zero inputs
// - data read returns pin levels
module rrit_decode
  import rrit_pkg::*;
#(
  parameter bit CS_FIRST_IS_SELECT = 1'b1,
  parameter bit CS_SECOND_IS_SELECT = 1'b1,
  parameter logic [2:0] ROM_CODE = 3'h1,
  parameter logic [2:0] UNIT_CODE = 3'h0,
  parameter bit IGNORE_A8 = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire rrit_bus_t bus_req,
  input wire logic rom_region_select,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pb_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic rom_select,
  output logic ram_select,
  output logic io_timer_select,
  output rrit_pins_t pa_pins,
  output rrit_pins_t pb_pins
);

  // ----------------------------------------
  // chip select decode
  // ----------------------------------------
  rrit_state_t s;
  rrit_state_t next_s;
  rrit_acc_t acc;
  logic chip_select_first;
  logic chip_select_second;
  logic [2:0] sel_pins;
  logic [2:0] sel_mask;
  logic [2:0] unit_mask;
  logic rom_hit;
  logic nonrom_hit;
  logic unit_hit;
  logic [1:0] reg_sel;
  logic tick;
  logic set_flag;
  logic clr_flag;
  logic [10:0] div_lim;

  // pins masked as port lines never take part in the compare
  assign chip_select_first = pb_in[`RRIT_PIN_CS_FIRST];
  assign chip_select_second = pb_in[`RRIT_PIN_CS_SECOND];
  assign sel_pins = {chip_select_second, chip_select_first, rom_region_select};
  assign sel_mask = {CS_SECOND_IS_SELECT, CS_FIRST_IS_SELECT, 1'b1};
  assign unit_mask = {~IGNORE_A8, 2'h3};

  // rom on its own code, a9..a6 ignored; other regions need all-low code
  assign rom_hit = ((sel_pins ^ ROM_CODE) & sel_mask) == 3'h0;
  assign nonrom_hit = (sel_pins & sel_mask) == 3'h0;
  assign unit_hit = ((bus_req.addr[`RRIT_A_UNIT_HI:`RRIT_A_UNIT_LO] ^ UNIT_CODE)
                     & unit_mask) == 3'h0;

  // region strobes follow the enable; rom answers reads only
  assign rom_select = bus_req.enable & bus_req.rw & rom_hit;
  assign ram_select = bus_req.enable & nonrom_hit & unit_hit
                      & ~bus_req.addr[`RRIT_A_RAM9];
  assign io_timer_select = bus_req.enable & nonrom_hit & unit_hit
                           & bus_req.addr[`RRIT_A_RAM9];
  assign reg_sel = bus_req.addr[1:0];

  // ----------------------------------------
  // access classification inside io-timer region
  // ----------------------------------------
  always_comb
  begin
    acc = RRIT_ACC_NONE;
    if (io_timer_select)
    begin
      if (!bus_req.addr[`RRIT_A_TIMER])
        acc = RRIT_ACC_PORT;
      else if (!bus_req.rw)
        acc = RRIT_ACC_TIMER_WR;
      else if (!bus_req.addr[0])
        acc = RRIT_ACC_COUNT_RD;
      else
        acc = RRIT_ACC_FLAG_RD;
    end
  end

  // ----------------------------------------
  // prescale and timer tick
  // ----------------------------------------
  // table of clock periods per count
  always_comb
  begin
    unique case (s.div_sel)
      2'h0: div_lim = `RRIT_DIV_1;
      2'h1: div_lim = `RRIT_DIV_8;
      2'h2: div_lim = `RRIT_DIV_64;
      2'h3: div_lim = `RRIT_DIV_1024;
    endcase
  end

  // once the flag stands the count runs at the full clock rate
  assign tick = s.flag | (s.presc == 11'(div_lim - 11'h001));
  assign set_flag = tick & ~s.flag & (s.count == 8'h00);
  // only count reads and writes clear; a flag read is a pure status look
  assign clr_flag = (acc == RRIT_ACC_TIMER_WR) | (acc == RRIT_ACC_COUNT_RD);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    // free-running prescale, restarted on every timer write
    next_s.presc = tick ? `RRIT_RST_PRESC : 11'(s.presc + 11'h001);
    if (tick)
      next_s.count = 8'(s.count - 8'h01);
    // set wins over a clear in the same cycle
    next_s.flag = set_flag | (s.flag & ~clr_flag);
    unique case (acc)
      RRIT_ACC_NONE:
      begin
        next_s.rd_valid = 1'b0;
      end
      RRIT_ACC_PORT:
      begin
        next_s.rd_valid = bus_req.rw;
        unique case (reg_sel)
          `RRIT_SEL_PA_DATA:
          begin
            next_s.rd_data = pa_in;
            if (!bus_req.rw)
              next_s.pa_data = bus_req.wdata;
          end
          `RRIT_SEL_PA_DIR:
          begin
            next_s.rd_data = s.pa_dir;
            if (!bus_req.rw)
              next_s.pa_dir = bus_req.wdata;
          end
          `RRIT_SEL_PB_DATA:
          begin
            next_s.rd_data = pb_in;
            if (!bus_req.rw)
              next_s.pb_data = bus_req.wdata;
          end
          `RRIT_SEL_PB_DIR:
          begin
            next_s.rd_data = s.pb_dir;
            if (!bus_req.rw)
              next_s.pb_dir = bus_req.wdata;
          end
        endcase
      end
      RRIT_ACC_TIMER_WR:
      begin
        next_s.count = bus_req.wdata;
        next_s.div_sel = reg_sel;
        next_s.irq_en = bus_req.addr[`RRIT_A_IRQEN];
        next_s.presc = `RRIT_RST_PRESC;
      end
      RRIT_ACC_COUNT_RD:
      begin
        next_s.rd_valid = 1'b1;
        next_s.rd_data = s.count;
        // a3 low stops further pin interrupts until the next write
        if (!bus_req.addr[`RRIT_A_IRQEN])
          next_s.irq_en = 1'b0;
      end
      RRIT_ACC_FLAG_RD:
      begin
        next_s.rd_valid = 1'b1;
        next_s.rd_data = `RRIT_RST_BYTE;
        next_s.rd_data[`RRIT_FLAG_BIT] = s.flag;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.div_sel <= `RRIT_RST_DIV;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // read data stands one cycle after the access
  assign data_out = s.rd_data;
  assign data_oe = s.rd_valid;
  assign pa_pins.out = s.pa_data;
  assign pa_pins.oe = s.pa_dir;

  // per-bit port b drive: chip-select pins never driven, bit 7 may carry irq
  for (genvar i = 0; i < 8; i++)
  begin : g_pb
    if (i == `RRIT_PIN_IRQ)
    begin : g_irq
      // plain assigns per bit, so no process owns the whole port struct
      assign pb_pins.out[i] = (s.flag && s.irq_en) ? 1'b0 : s.pb_data[i];
      assign pb_pins.oe[i] = (s.flag && s.irq_en) ? 1'b1 : s.pb_dir[i];
    end
    else
    begin : g_plain
      logic is_cs;
      assign is_cs = ((i == `RRIT_PIN_CS_FIRST) && CS_FIRST_IS_SELECT)
                     || ((i == `RRIT_PIN_CS_SECOND) && CS_SECOND_IS_SELECT);
      assign pb_pins.out[i] = s.pb_data[i];
      assign pb_pins.oe[i] = s.pb_dir[i] & ~is_cs;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_ROM_READ_ONLY:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      rom_select |-> bus_req.rw)
    else $error("rom selected on a write");

  AST_PORT_NEEDS_A2_LOW:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      !(acc == RRIT_ACC_PORT) |=> $stable(s.pa_dir) && $stable(s.pb_data))
    else $error("port register changed without a port access");

  AST_DIR_WRITE:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_PORT && !bus_req.rw && reg_sel == `RRIT_SEL_PA_DIR
      |=> pa_pins.oe == $past(bus_req.wdata))
    else $error("direction write did not reach the pin enables");

  AST_PRESCALE_EIGHT:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_TIMER_WR && reg_sel == 2'h1 && bus_req.wdata != 8'h00
      ##1 (!bus_req.enable)[*8]
      |=> s.count == 8'($past(bus_req.wdata, 9) - 8'h01))
    else $error("divide by eight count step mistimed");

  AST_IRQ_ENABLE_WRITE:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_TIMER_WR |=> s.irq_en == $past(bus_req.addr[`RRIT_A_IRQEN]))
    else $error("irq routing not taken from a3");

  AST_COUNT_READ_DISABLES:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_COUNT_RD && !bus_req.addr[`RRIT_A_IRQEN]
      |=> !s.irq_en && data_oe && data_out == $past(s.count))
    else $error("count read wrong or routing left on");

  AST_FLAG_READ:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_FLAG_RD |=> data_oe && data_out[`RRIT_FLAG_BIT] == $past(s.flag))
    else $error("flag read returned wrong value");

  AST_ZERO_BEFORE_FLAG:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(s.flag) && $past(acc) != RRIT_ACC_TIMER_WR
      |-> $past(s.count) == 8'h00 && s.count == 8'hFF)
    else $error("flag set from a nonzero count");

  AST_RUN_AFTER_FLAG:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      s.flag && acc != RRIT_ACC_TIMER_WR ##1 s.flag
      |-> s.count == 8'($past(s.count) - 8'h01))
    else $error("count not decrementing each clock after flag");

  AST_SET_WINS:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      set_flag |=> s.flag)
    else $error("flag lost in set cycle");

  AST_ACCESS_CLEARS:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      s.flag && clr_flag |=> !s.flag)
    else $error("timer access did not clear the flag");

  AST_IRQ_PIN_LOW:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      s.flag && s.irq_en |-> pb_pins.oe[`RRIT_PIN_IRQ] && !pb_pins.out[`RRIT_PIN_IRQ])
    else $error("irq pin not pulled low");

  AST_PIN_LEVEL_READ:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_PORT && bus_req.rw && reg_sel == `RRIT_SEL_PA_DATA
      |=> data_oe && data_out == $past(pa_in))
    else $error("port read did not return pin levels");

  AST_PB_DIR_WRITE:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_PORT && !bus_req.rw && reg_sel == `RRIT_SEL_PB_DIR
      |=> s.pb_dir == $past(bus_req.wdata))
    else $error("port b direction write lost");

  AST_TIMER_LOAD:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_TIMER_WR
      |=> s.count == $past(bus_req.wdata) && s.div_sel == $past(reg_sel))
    else $error("timer write did not load count and prescale");

  AST_FLAG_READ_CLEAN:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      acc == RRIT_ACC_FLAG_RD |=> data_out[6:0] == 7'h00)
    else $error("flag read carried stray bits");

  AST_ANSWER_ONLY_READS:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      !(io_timer_select && bus_req.rw) |=> !data_oe)
    else $error("read data driven without a read");

  AST_CS_PIN_UNDRIVEN:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      !CS_FIRST_IS_SELECT || !pb_pins.oe[`RRIT_PIN_CS_FIRST])
    else $error("select pin driven as an output");

  AST_IO_NEEDS_A9:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
      io_timer_select
      |-> bus_req.addr[`RRIT_A_RAM9] && !ram_select && !rom_select)
    else $error("io region overlaps another region");

endmodule // rrit_decode

// file: pkg/rrit_cfg.svh
`ifndef RRIT_CFG_SVH
`define RRIT_CFG_SVH

// ----------------------------------------
// address field positions
// ----------------------------------------
`define RRIT_A_TIMER 2
`define RRIT_A_IRQEN 3
`define RRIT_A_RAM9 9
`define RRIT_A_UNIT_HI 8
`define RRIT_A_UNIT_LO 6
`define RRIT_A_A8 8

// ----------------------------------------
// port register select codes on a1:a0
// ----------------------------------------
`define RRIT_SEL_PA_DATA 2'h0
`define RRIT_SEL_PA_DIR 2'h1
`define RRIT_SEL_PB_DATA 2'h2
`define RRIT_SEL_PB_DIR 2'h3

// ----------------------------------------
// prescale periods in clock periods per count
// ----------------------------------------
`define RRIT_DIV_1 11'h001
`define RRIT_DIV_8 11'h008
`define RRIT_DIV_64 11'h040
`define RRIT_DIV_1024 11'h400

// ----------------------------------------
// pin and bit positions, reset values
// ----------------------------------------
`define RRIT_FLAG_BIT 7
`define RRIT_PIN_IRQ 7
`define RRIT_PIN_CS_FIRST 6
`define RRIT_PIN_CS_SECOND 5
`define RRIT_RST_BYTE 8'h00
`define RRIT_RST_PRESC 11'h000
`define RRIT_RST_DIV 2'h0

`endif

// file: pkg/rrit_pkg.sv
package rrit_pkg;

  // bus request from the processor, one access per enable cycle
  typedef struct packed {
    logic enable;
    logic rw;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rrit_bus_t;

  // peripheral pin drive for one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } rrit_pins_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] pa_data;
    logic [7:0] pa_dir;
    logic [7:0] pb_data;
    logic [7:0] pb_dir;
    logic [7:0] count;
    logic [10:0] presc;
    logic [1:0] div_sel;
    logic flag;
    logic irq_en;
    logic [7:0] rd_data;
    logic rd_valid;
  } rrit_state_t;

  // decoded access kind
  typedef enum logic [2:0] {
    RRIT_ACC_NONE,
    RRIT_ACC_PORT,
    RRIT_ACC_TIMER_WR,
    RRIT_ACC_COUNT_RD,
    RRIT_ACC_FLAG_RD
  } rrit_acc_t;

endpackage

// file: tb/rrit_pin_world.sv
`timescale 1ns/1ps

// ----------------------------------------
// peripheral side of one 8-bit port
// ----------------------------------------
module rrit_pin_world
  import rrit_pkg::*;
(
  input wire rrit_pins_t pins,
  input wire logic [7:0] ext,
  output logic [7:0] level
);
  // device wins where it drives, else the outside level (pull-up lives in ext)
  assign level = (pins.oe & pins.out) | (~pins.oe & ext);
endmodule // rrit_pin_world

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module testbench;
  import rrit_pkg::*;
  logic sys_clk, reset_n, rs, data_oe, rom_sel, ram_sel, io_sel, rw;
  logic rom_sel1, ram_sel1, io_sel1;
  rrit_bus_t bus;
  logic [7:0] pa_ext, pb_ext, pa_lvl, pb_lvl, data_out, e8, bdir;
  logic [9:0] a;
  logic [2:0] c;
  rrit_pins_t pa_pins, pb_pins;
  int failures, num_checks, seed, n, p, dly;
  logic [7:0] mreg [4];

  rrit_decode uut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus),
    .rom_region_select(rs), .pa_in(pa_lvl), .pb_in(pb_lvl), .data_out(data_out),
    .data_oe(data_oe), .rom_select(rom_sel), .ram_select(ram_sel),
    .io_timer_select(io_sel), .pa_pins(pa_pins), .pb_pins(pb_pins));
  // single-device variant: a8 ignored, second select pin is a port line
  rrit_decode #(.CS_SECOND_IS_SELECT(1'b0), .IGNORE_A8(1'b1)) uut_single (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus), .rom_region_select(rs),
    .pa_in(pa_lvl), .pb_in(pb_lvl), .data_out(), .data_oe(), .rom_select(rom_sel1),
    .ram_select(ram_sel1), .io_timer_select(io_sel1), .pa_pins(), .pb_pins());
  rrit_pin_world pw_a (.pins(pa_pins), .ext(pa_ext), .level(pa_lvl));
  rrit_pin_world pw_b (.pins(pb_pins), .ext(pb_ext), .level(pb_lvl));

  // ----------------------------------------
  // clock, bus access, verdict
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // one access; returns one step after the access edge so data_oe has landed
  task acc(input logic wr_n, input logic [9:0] ad, input logic [7:0] wd);
    @(posedge sys_clk);
    bus <= '{1'b1, wr_n, ad, wd};
    @(posedge sys_clk);
    bus.enable <= 1'b0;
    #1;
  endtask

  task tally_and_finish;
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: full run is a few thousand cycles; this span is 25000
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    seed = 11;
    reset_n = 1'b0;
    rs = 1'b0;
    bus = '0;
    pa_ext = 8'hFF;
    pb_ext = 8'h9F; // selects low for the io region
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    // fill all four port registers
    for (int i = 0; i < 4; i++)
    begin
      e8 = $random(seed);
      mreg[i] = e8;
      acc(1'b0, 10'h200 | 10'(i), e8);
    end
    bdir = mreg[3] & 8'h9F; // select pins never driven
    `CHK("pa_oe", mreg[1], pa_pins.oe)
    `CHK("pa_out", mreg[1] & mreg[0], pa_pins.out & pa_pins.oe)
    `CHK("pb_oe", bdir, pb_pins.oe)
    `CHK("pb_out", bdir & mreg[2], pb_pins.out & pb_pins.oe)
    // reads: data returns pin levels, direction the register
    for (int i = 0; i < 4; i++)
    begin
      pa_ext = $random(seed);
      pb_ext = $random(seed) & 8'h9F;
      e8 = (i == 0) ? ((mreg[1] & mreg[0]) | (~mreg[1] & pa_ext)) :
           (i == 2) ? ((bdir & mreg[2]) | (~bdir & pb_ext)) : mreg[i];
      acc(1'b1, 10'h200 | 10'(i), 8'h00);
      `CHK("port_rd_oe", 1'b1, data_oe)
      `CHK("port_rd", e8, data_out)
    end
    // every prescale; read midway between ticks
    for (int d = 0; d < 4; d++)
    begin
      p = (d == 0) ? 1 : (d == 1) ? 8 : (d == 2) ? 64 : 1024;
      n = 5 + ($random(seed) & 8'h3F);
      acc(1'b0, 10'h204 | 10'(d) | (10'($random(seed) & 1) << 3), 8'(n));
      dly = 2 * p + p / 2 - 1;
      repeat (dly) @(posedge sys_clk);
      acc(1'b1, 10'h20C, 8'h00);
      `CHK("count", 8'(n - 2), data_out)
    end
    // flag with routing, then clear by a count read
    acc(1'b0, 10'h20C, 8'h03);
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK("irq_oe", 1'b1, pb_pins.oe[7])
    `CHK("irq_out", 1'b0, pb_pins.out[7])
    acc(1'b1, 10'h205, 8'h00);
    `CHK("flag_rd", 8'h80, data_out)
    acc(1'b1, 10'h204, 8'h00);
    `CHK("count_after", 8'hF6, data_out)
    `CHK("irq_off", mreg[3][7], pb_pins.oe[7])
    acc(1'b1, 10'h205, 8'h00);
    `CHK("flag_clr", 8'h00, data_out)
    // region decode: random codes, addresses and directions
    for (int i = 0; i < 60; i++)
    begin
      @(posedge sys_clk);
      c = ($random(seed) & 1) ? 3'h0 : 3'($random(seed));
      a = 10'($random(seed));
      if ($random(seed) & 1)
        a[8:6] = 3'h0;
      rw = 1'($random(seed));
      rs <= c[0];
      pb_ext <= {1'b1, c[1], c[2], 5'h1F}; // select pins first, second
      bus <= '{1'b1, rw, a, 8'h00};
      #1;
      `CHK("rom_sel", rw && c == 3'h1, rom_sel)
      `CHK("ram_sel", c == 3'h0 && !a[9] && a[8:6] == 3'h0, ram_sel)
      `CHK("io_sel", c == 3'h0 && a[9] && a[8:6] == 3'h0, io_sel)
      `CHK("rom_sel_1", rw && c[1:0] == 2'h1, rom_sel1)
      `CHK("ram_sel_1", c[1:0] == 2'h0 && !a[9] && a[7:6] == 2'h0, ram_sel1)
      `CHK("io_sel_1", c[1:0] == 2'h0 && a[9] && a[7:6] == 2'h0, io_sel1)
    end
    @(posedge sys_clk);
    bus.enable <= 1'b0;
    tally_and_finish();
  end
endmodule // testbench
